// ### rtl/fpc_ctrl_reg.sv
// Top: 64-bit FP control register with trap check and datapath controls
// Notes on behaviour
// - Bit 26 picks IEEE or alternative half.
// - Half format bit affects only conversions.
// - Bit 25 forces default NaN results.
// - Bit 24 enables single/double flush-to-zero.
// - Single/double flush never touches half math.
// - Bits 23:22 encode rounding mode.
// - Scalar and vector share rounding mode.
// - Bit 19 enables half flush-to-zero.
// - Half flush raises no input-denormal flag.
// - Reserved bits reset to zero.
// - Top-level trap bit traps access, class 0x07.
`default_nettype none
module fpc_ctrl_reg (
  input  wire logic        clk,           // Core clock, 25 MHz
  input  wire logic        rst_n,         // Sync reset, active low
  input  wire logic        regWr,         // Register write request
  input  wire logic        regRd,         // Register read request
  input  wire logic [63:0] regWdata,      // Write data
  input  wire logic        fpTrapTopLevel,// Top-level FP trap bit
  input  wire logic        isHalfOp,      // Native half-precision op
  input  wire logic        isHalfConv,    // Half conversion op
  output logic [63:0]      regRdata,      // Read data
  output logic             regDone,       // Access completed, pulse
  output logic             accessTrap,    // Access trapped, pulse
  output logic [5:0]       trapClass,     // Syndrome class of trap
  output logic             useAltHalf,    // Effective alt half format
  output logic             forceDefNan,   // Effective default NaN
  output logic             flushDenorm,   // Effective flush to zero
  output logic             suppressIdc,   // No input-denormal flag
  output logic [1:0]       roundMode      // Effective rounding mode
);
  logic [63:0] reg_ff, nxt_reg, rdata_ff, nxt_rdata;
  logic        done_ff, nxt_done, trap_ff, nxt_trap;
  logic [5:0]  cls_ff, nxt_cls;
  logic        acc;

  fpc_cfg_if cfgBus ();

  ////////////////////////////////////////////////////////////////////////////
  // Register access
  always_comb begin
    acc       = regWr | regRd;
    nxt_reg   = reg_ff;
    nxt_rdata = rdata_ff;
    nxt_done  = 1'b0;
    nxt_trap  = 1'b0;
    nxt_cls   = cls_ff;
    if (acc && fpTrapTopLevel) begin
      nxt_trap = 1'b1;
      nxt_cls  = fpc_pkg::TRAP_CLASS;
    end else if (acc) begin
      nxt_done = 1'b1;
      if (regWr)
        nxt_reg = regWdata & fpc_pkg::WRITE_MASK;
      if (regRd)
        nxt_rdata = reg_ff & fpc_pkg::WRITE_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_ff   <= fpc_pkg::RESET_VALUE;
      rdata_ff <= 64'h0000_0000_0000_0000;
      done_ff  <= 1'b0;
      trap_ff  <= 1'b0;
      cls_ff   <= 6'h00;
    end else begin
      reg_ff   <= nxt_reg;
      rdata_ff <= nxt_rdata;
      done_ff  <= nxt_done;
      trap_ff  <= nxt_trap;
      cls_ff   <= nxt_cls;
    end
  end

  assign regRdata   = rdata_ff;
  assign regDone    = done_ff;
  assign accessTrap = trap_ff;
  assign trapClass  = cls_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Field fan-out
  assign cfgBus.altHalfPrecSel  = reg_ff[fpc_pkg::ALT_HALF_BIT];
  assign cfgBus.defaultNanEn    = reg_ff[fpc_pkg::DEF_NAN_BIT];
  assign cfgBus.flushZeroEn     = reg_ff[fpc_pkg::FLUSH_BIT];
  assign cfgBus.flushZeroHalfEn = reg_ff[fpc_pkg::FLUSH_H_BIT];
  assign cfgBus.roundModeSel    = reg_ff[fpc_pkg::RND_HI:fpc_pkg::RND_LO];

  fpc_decode uDecode (
    .clk         (clk),
    .rst_n       (rst_n),
    .cfg         (cfgBus),
    .isHalfOp    (isHalfOp),
    .isHalfConv  (isHalfConv),
    .useAltHalf  (useAltHalf),
    .forceDefNan (forceDefNan),
    .flushDenorm (flushDenorm),
    .suppressIdc (suppressIdc),
    .roundMode   (roundMode)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Trap path
  AST_TRAP: assert property (@(posedge clk) disable iff (!rst_n)
    (regWr | regRd) && fpTrapTopLevel |=> accessTrap
      && trapClass == fpc_pkg::TRAP_CLASS && !regDone)
    else $error("trapped access not reported");
  AST_NOWR_TRAP: assert property (@(posedge clk) disable iff (!rst_n)
    regWr && fpTrapTopLevel |=> $stable(reg_ff))
    else $error("trapped write changed register");
  AST_DONE: assert property (@(posedge clk) disable iff (!rst_n)
    (regWr | regRd) && !fpTrapTopLevel |=> regDone && !accessTrap)
    else $error("untrapped access not completed");
  AST_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    !(regWr | regRd) |=> !regDone && !accessTrap)
    else $error("answer without access");
  AST_CLS_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !((regWr | regRd) && fpTrapTopLevel) |=> $stable(trapClass))
    else $error("trap class changed without trap");
  AST_RD_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !(regRd && !fpTrapTopLevel) |=> $stable(regRdata))
    else $error("read data changed without read");

  // Storage and readback
  AST_READ: assert property (@(posedge clk) disable iff (!rst_n)
    regRd && !fpTrapTopLevel |=>
      regRdata == ($past(reg_ff) & fpc_pkg::WRITE_MASK))
    else $error("read data not register value");
  AST_WR_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !(regWr && !fpTrapTopLevel) |=> $stable(reg_ff))
    else $error("register changed without write");
  AST_FLAGS_WR: assert property (@(posedge clk) disable iff (!rst_n)
    regWr && !fpTrapTopLevel |=>
      reg_ff[fpc_pkg::FLUSH_BIT] == $past(regWdata[fpc_pkg::FLUSH_BIT])
      && reg_ff[fpc_pkg::FLUSH_H_BIT] == $past(regWdata[fpc_pkg::FLUSH_H_BIT])
      && reg_ff[fpc_pkg::DEF_NAN_BIT] == $past(regWdata[fpc_pkg::DEF_NAN_BIT]))
    else $error("flag write not stored");

  // Reserved bits read as zero, checked one bit at a time
  for (genvar b = 0; b < fpc_pkg::REG_W; b++) begin : gRsvd
    if (!fpc_pkg::WRITE_MASK[b]) begin : gBit
      AST_RSVD_BIT: assert property (@(posedge clk) disable iff (!rst_n)
        regRdata[b] == 1'b0 && reg_ff[b] == 1'b0)
        else $error("reserved bit set");
    end
  end

  // Field controls
  AST_RSVD: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_ff & ~fpc_pkg::WRITE_MASK) == 64'h0 && regRdata[18:0] == 19'h0)
    else $error("reserved bits nonzero");
  AST_RESET: assert property (@(posedge clk)
    !rst_n |=> reg_ff == 64'h0)
    else $error("register not reset to zero");
  AST_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    regWr && !fpTrapTopLevel |=> reg_ff[23:22] == $past(regWdata[23:22])
      && reg_ff[26] == $past(regWdata[26]))
    else $error("write not stored");
  AST_DEF_NAN: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> forceDefNan == $past(reg_ff[fpc_pkg::DEF_NAN_BIT]))
    else $error("default NaN not applied");
  AST_HALF_FLUSH: assert property (@(posedge clk) disable iff (!rst_n)
    isHalfOp |=> flushDenorm == $past(reg_ff[fpc_pkg::FLUSH_H_BIT])
      && suppressIdc == $past(reg_ff[fpc_pkg::FLUSH_H_BIT]))
    else $error("half flush wrong");
  AST_FLUSH: assert property (@(posedge clk) disable iff (!rst_n)
    !isHalfOp |=> flushDenorm == $past(reg_ff[fpc_pkg::FLUSH_BIT])
      && !suppressIdc)
    else $error("single flush wrong");
  AST_ALT_NATIVE: assert property (@(posedge clk) disable iff (!rst_n)
    isHalfOp || !isHalfConv |=> !useAltHalf)
    else $error("alt half used outside conversion");
  AST_ALT_CONV: assert property (@(posedge clk) disable iff (!rst_n)
    isHalfConv && !isHalfOp |=>
      useAltHalf == $past(reg_ff[fpc_pkg::ALT_HALF_BIT]))
    else $error("alt half select not applied");
  AST_ROUND: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> roundMode == $past(reg_ff[fpc_pkg::RND_HI:fpc_pkg::RND_LO]))
    else $error("rounding mode not applied");

  COV_WRITE: cover property (@(posedge clk) regWr && !fpTrapTopLevel);
  COV_TRAP:  cover property (@(posedge clk) regRd && fpTrapTopLevel);
  COV_HALF:  cover property (@(posedge clk)
    isHalfOp && reg_ff[fpc_pkg::FLUSH_H_BIT]);
  COV_ZERO:  cover property (@(posedge clk) roundMode == 2'h3);
  COV_CONV:  cover property (@(posedge clk) useAltHalf);
endmodule
`default_nettype wire

// ### rtl/fpc_decode.sv
// Per-unit decode of FP configuration into effective datapath controls
`default_nettype none
module fpc_decode (
  input  wire logic clk,          // Core clock
  input  wire logic rst_n,        // Sync reset, active low
  fpc_cfg_if.dst    cfg,          // Configuration from the register
  input  wire logic isHalfOp,     // Operation is native half-precision
  input  wire logic isHalfConv,   // Operation converts to/from half
  output logic      useAltHalf,   // Use alternative half format
  output logic      forceDefNan,  // Return default NaN on NaN input
  output logic      flushDenorm,  // Flush denormals to zero
  output logic      suppressIdc,  // Flushed half raises no denormal flag
  output logic [1:0] roundMode    // Effective rounding mode
);
  logic       nxt_alt, nxt_nan, nxt_flush, nxt_sup;
  logic [1:0] nxt_round;
  logic       alt_ff, nan_ff, flush_ff, sup_ff;
  logic [1:0] round_ff;

  always_comb begin
    nxt_alt = cfg.altHalfPrecSel & isHalfConv & ~isHalfOp;
    nxt_nan   = cfg.defaultNanEn;
    nxt_flush = isHalfOp ? cfg.flushZeroHalfEn
                         : cfg.flushZeroEn;
    nxt_sup   = isHalfOp & cfg.flushZeroHalfEn;
    nxt_round = cfg.roundModeSel;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alt_ff   <= 1'b0;
      nan_ff   <= 1'b0;
      flush_ff <= 1'b0;
      sup_ff   <= 1'b0;
      round_ff <= 2'h0;
    end else begin
      alt_ff   <= nxt_alt;
      nan_ff   <= nxt_nan;
      flush_ff <= nxt_flush;
      sup_ff   <= nxt_sup;
      round_ff <= nxt_round;
    end
  end

  assign useAltHalf  = alt_ff;
  assign forceDefNan = nan_ff;
  assign flushDenorm = flush_ff;
  assign suppressIdc = sup_ff;
  assign roundMode   = round_ff;
endmodule
`default_nettype wire

// ### rtl/fpc_if.sv
// Interface: decoded FP configuration handed from the register to consumers
`default_nettype none
interface fpc_cfg_if;
  logic       altHalfPrecSel;
  logic       defaultNanEn;
  logic       flushZeroEn;
  logic       flushZeroHalfEn;
  logic [1:0] roundModeSel;
  modport src (output altHalfPrecSel, defaultNanEn, flushZeroEn,
               flushZeroHalfEn, roundModeSel);
  modport dst (input altHalfPrecSel, defaultNanEn, flushZeroEn,
               flushZeroHalfEn, roundModeSel);
endinterface
`default_nettype wire

// ### rtl/fpc_pkg.sv
// Package: field layout, encodings and access codes of the FP control register
`default_nettype none
package fpc_pkg;
  localparam int          REG_W        = 64;
  localparam int          ALT_HALF_BIT = 26;
  localparam int          DEF_NAN_BIT  = 25;
  localparam int          FLUSH_BIT    = 24;
  localparam int          RND_HI       = 23;
  localparam int          RND_LO       = 22;
  localparam int          FLUSH_H_BIT  = 19;
  localparam logic [63:0] WRITE_MASK   = 64'h0000_0000_07C8_0000;
  localparam logic [63:0] RESET_VALUE  = 64'h0000_0000_0000_0000;
  localparam logic [5:0]  TRAP_CLASS   = 6'h07;
  typedef enum logic [1:0] {
    RND_NEAREST = 2'h0,
    RND_PLUS    = 2'h1,
    RND_MINUS   = 2'h2,
    RND_ZERO    = 2'h3
  } fpc_round_t;
endpackage
`default_nettype wire

// ### tb/tb_fp_control_register.sv
// Testbench: self-checking bench for the FP control register
`default_nettype none
module tb_fp_control_register;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, regWr, regRd, fpTrapTopLevel;
  logic        isHalfOp, isHalfConv, regDone, accessTrap;
  logic        useAltHalf, forceDefNan, flushDenorm, suppressIdc;
  logic [63:0] regWdata, regRdata;
  logic [5:0]  trapClass;
  logic [1:0]  roundMode;
  int          errCount;
  int          totalChecks;
  int          cycles;
  fpc_ctrl_reg uut (.clk(clk), .rst_n(rst_n), .regWr(regWr), .regRd(regRd),
    .regWdata(regWdata), .fpTrapTopLevel(fpTrapTopLevel),
    .isHalfOp(isHalfOp), .isHalfConv(isHalfConv), .regRdata(regRdata),
    .regDone(regDone), .accessTrap(accessTrap), .trapClass(trapClass),
    .useAltHalf(useAltHalf), .forceDefNan(forceDefNan),
    .flushDenorm(flushDenorm), .suppressIdc(suppressIdc),
    .roundMode(roundMode));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string msg);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles > 2000) begin
      errCount++;
      complete_run();
    end
  end
  // One access held for one edge; answer checked just after that edge
  task automatic acc(input logic wr, input logic rd, input logic [63:0] d,
                     input logic trap);
    @(posedge clk);
    regWr <= wr;
    regRd <= rd;
    regWdata <= d;
    fpTrapTopLevel <= trap;
    @(posedge clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    fpTrapTopLevel <= 1'b0;
    #1;
    chk(regDone, !trap, "done");
    chk(accessTrap, trap, "trap");
  endtask
  task automatic settle(input logic hop, input logic hconv);
    @(posedge clk);
    isHalfOp <= hop;
    isHalfConv <= hconv;
    repeat (3) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    acc(1'b0, 1'b1, 64'h0, 1'b0);
    chk(regRdata, 64'h0, "reset value");
    chk({forceDefNan, flushDenorm, roundMode}, 64'h0, "reset fields");
    acc(1'b1, 1'b0, 64'hFFFF_FFFF_FFFF_FFFF, 1'b0);
    acc(1'b0, 1'b1, 64'h0, 1'b0);
    chk(regRdata, 64'h0000_0000_07C8_0000, "reserved bits");
    settle(1'b0, 1'b0);
    chk(forceDefNan, 1'b1, "default nan on");
    $display("test reset_mask done");
  endtask
  task automatic t_round();
    for (int m = 0; m < 4; m++) begin
      acc(1'b1, 1'b0, 64'(m) << 22, 1'b0);
      settle(1'b0, 1'b0);
      chk(roundMode, 64'(m), "round mode");
      settle(1'b1, 1'b0);
      chk(roundMode, 64'(m), "round mode half");
    end
    $display("test round done");
  endtask
  task automatic t_trap();
    acc(1'b1, 1'b0, 64'hFFFF_FFFF_FFFF_FFFF, 1'b1);
    chk(trapClass, 64'h07, "trap class");
    acc(1'b0, 1'b1, 64'h0, 1'b1);
    chk(regRdata, 64'h0000_0000_07C8_0000, "trapped read");
    acc(1'b0, 1'b1, 64'h0, 1'b0);
    chk(regRdata, 64'h0000_0000_00C0_0000, "write refused");
    $display("test trap done");
  endtask
  task automatic t_half();
    acc(1'b1, 1'b0, 64'h0000_0000_0100_0000, 1'b0);
    settle(1'b1, 1'b0);
    chk(flushDenorm, 1'b0, "fz on half");
    settle(1'b0, 1'b0);
    chk(flushDenorm, 1'b1, "fz single");
    acc(1'b1, 1'b0, 64'h0000_0000_0008_0000, 1'b0);
    settle(1'b1, 1'b0);
    chk({flushDenorm, suppressIdc}, 64'h3, "fz half");
    settle(1'b0, 1'b0);
    chk({flushDenorm, suppressIdc}, 64'h0, "fz half off");
    acc(1'b1, 1'b0, 64'h0000_0000_0400_0000, 1'b0);
    settle(1'b0, 1'b1);
    chk(useAltHalf, 1'b1, "alt conv");
    settle(1'b1, 1'b1);
    chk(useAltHalf, 1'b0, "alt native");
    acc(1'b1, 1'b0, 64'h0, 1'b0);
    settle(1'b0, 1'b1);
    chk({useAltHalf, forceDefNan}, 64'h0, "ieee conv");
    $display("test half done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, regWr, regRd, fpTrapTopLevel, isHalfOp, isHalfConv} = 6'h00;
    regWdata = 64'h0;
    errCount = 0;
    totalChecks = 0;
    cycles = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_round();
    t_trap();
    t_half();
    complete_run();
  end
endmodule
`default_nettype wire
